//--- logic/rh_power_defines.svh
// Offsets, field positions and reset values of the root hub power block
`ifndef RH_POWER_DEFINES_SVH
`define RH_POWER_DEFINES_SVH
`define ADDR_GLOBAL_STATUS 32'h90101050
`define ADDR_PORT_POWER_REMOVABLE 32'h9010104c
`define ADDR_IRQ_STATUS 32'h90101100
`define ADDR_IRQ_MASK 32'h90101104
`define ADDR_PORT_CMD 32'h90101108
`define ADDR_PORT_POWER 32'h9010110c
`define BIT_POWER_OFF 0
`define BIT_OVERCURRENT 1
`define BIT_WAKE_EN 15
`define BIT_POWER_ON 16
`define BIT_OC_CHANGE 17
`define BIT_CLR_WAKE 31
`define PORT_VALID_MASK 16'hfffe
`define DESC_B_RESET 32'h00000000
`define IRQ_BIT_RESUME 0
`define IRQ_BIT_OC_CHANGE 1
`define IRQ_WIDTH 2
`endif

//--- logic/rh_power_pkg.sv
// Types shared by the root hub power block
package rh_power_pkg;
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	typedef struct packed {
		logic power_switching_select_mode;
		logic per_port_overcurrent;
		logic global_overcurrent;
	} hub_cfg_t;
endpackage : rh_power_pkg

//--- logic/usb_root_hub_power_status.sv
// Root hub global power, overcurrent and wakeup status logic
//
// Notes on behaviour
// RULE1: Per-port mode: masked ports change power only by per-port commands.
// RULE2: Per-port mode: unmasked ports follow only global power commands.
// RULE3: Global switching mode ignores the port power mask.
// RULE4: Mask bit 0 reserved; bits 1..15 map to ports 1..15.
// RULE5: Sixteen bit non-removable field, set means not removable.
// RULE6: Removable bit 0 reserved; bits 1..15 map to ports 1..15.
// RULE7: Status bit 31 write-only; one clears wakeup enable.
// RULE8: Overcurrent change flag sets on indicator change; write one clears.
// RULE9: Status bit 16 always reads zero.
// RULE10: Global mode: writing one to bit 16 powers all ports.
// RULE11: Per-port mode: power-on sets only unmasked ports.
// RULE12: Wakeup enable makes connection change a resume event.
// RULE13: Overcurrent indicator reads one during global overcurrent.
// RULE14: Per-port overcurrent reporting forces indicator to zero.
// RULE15: Mode zero powers all ports together; one powers individually.
// RULE16: Writing one to bit 0 removes power; per-port only unmasked ports.
// RULE17: Unused status bits read as zero.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "rh_power_defines.svh"
module usb_root_hub_power_status (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire rh_power_pkg::reg_req_t req_i,
	output logic [31:0] rdata_o,
	input wire rh_power_pkg::hub_cfg_t cfg_i,
	input wire logic [15:0] connection_change_flag_i,
	output logic [15:0] port_powered_state_o,
	output logic resume_seen_interrupt_o,
	output logic irq_o
);
	import rh_power_pkg::*;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Config straps and pins come from outside this clock domain
	// Only the second stage is read, so no logic sees a settling value
	hub_cfg_t cfg_s1_reg;
	hub_cfg_t cfg_reg;
	logic [15:0] conn_s1_reg;
	logic [15:0] conn_reg;

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cfg_s1_reg <= '0;
			cfg_reg <= '0;
			conn_s1_reg <= 16'h0000;
			conn_reg <= 16'h0000;
		end
		else
		begin
			cfg_s1_reg <= cfg_i;
			cfg_reg <= cfg_s1_reg;
			conn_s1_reg <= connection_change_flag_i;
			conn_reg <= conn_s1_reg;
		end
	end

	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	function automatic logic hit(input reg_req_t r, input logic [31:0] a);
		hit = r.wr && (r.addr == a);
	endfunction : hit

	function automatic logic rd_hit(input reg_req_t r, input logic [31:0] a);
		rd_hit = r.rd && (r.addr == a);
	endfunction : rd_hit

	logic wr_status;
	logic wr_desc;
	logic wr_mask;
	logic wr_port_cmd;
	assign wr_status = hit(req_i, `ADDR_GLOBAL_STATUS);
	assign wr_desc = hit(req_i, `ADDR_PORT_POWER_REMOVABLE);
	assign wr_mask = hit(req_i, `ADDR_IRQ_MASK);
	assign wr_port_cmd = hit(req_i, `ADDR_PORT_CMD);
	logic rd_status;
	logic irq_rd;
	assign rd_status = rd_hit(req_i, `ADDR_GLOBAL_STATUS);
	assign irq_rd = rd_hit(req_i, `ADDR_IRQ_STATUS);

	logic global_power_on_cmd;
	logic global_power_off_cmd;
	assign global_power_on_cmd = wr_status && req_i.wdata[`BIT_POWER_ON];
	assign global_power_off_cmd = wr_status && req_i.wdata[`BIT_POWER_OFF];

	// ----------------------------------------
	// Descriptor register
	// ----------------------------------------
	logic [15:0] port_power_mask_reg;
	logic [15:0] device_nonremovable_bits_reg;

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			port_power_mask_reg <= 16'(`DESC_B_RESET >> 16);
			device_nonremovable_bits_reg <= 16'h0000;
		end
		else if (wr_desc)
		begin
			port_power_mask_reg <= req_i.wdata[31:16] & `PORT_VALID_MASK; // RULE4
			device_nonremovable_bits_reg <= req_i.wdata[15:0] & `PORT_VALID_MASK; // RULE5 RULE6
		end
	end

	// ----------------------------------------
	// Port power state
	// ----------------------------------------
	// Port command register, per-port mode only: upper half sets, lower half clears power of masked ports
	logic [15:0] global_sel;
	logic [15:0] port_sel;
	logic [15:0] port_powered_state_reg;
	logic [15:0] port_powered_state_next;

	always_comb
	begin
		if (!cfg_reg.power_switching_select_mode)
		begin
			global_sel = `PORT_VALID_MASK; // RULE3 RULE15
			port_sel = 16'h0000;
		end
		else
		begin
			global_sel = ~port_power_mask_reg & `PORT_VALID_MASK; // RULE2
			port_sel = port_power_mask_reg; // RULE1
		end
	end

	always_comb
	begin
		// Off follows on, so off wins when one write asks for both
		port_powered_state_next = port_powered_state_reg;
		if (global_power_on_cmd)
			port_powered_state_next = port_powered_state_next | global_sel; // RULE10 RULE11
		if (global_power_off_cmd)
			port_powered_state_next = port_powered_state_next & ~global_sel; // RULE16
		if (wr_port_cmd)
		begin
			port_powered_state_next = port_powered_state_next | (req_i.wdata[31:16] & port_sel);
			port_powered_state_next = port_powered_state_next & ~(req_i.wdata[15:0] & port_sel);
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			port_powered_state_reg <= 16'h0000;
		else
			port_powered_state_reg <= port_powered_state_next;
	end
	assign port_powered_state_o = port_powered_state_reg;

	// ----------------------------------------
	// Overcurrent
	// ----------------------------------------
	logic global_overcurrent_flag;
	logic oc_flag_prev_reg;
	logic overcurrent_change_flag_reg;
	assign global_overcurrent_flag = cfg_reg.global_overcurrent
		&& !cfg_reg.per_port_overcurrent; // RULE13 RULE14

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			oc_flag_prev_reg <= 1'b0;
			overcurrent_change_flag_reg <= 1'b0;
		end
		else
		begin
			oc_flag_prev_reg <= global_overcurrent_flag;
			// Set wins over a simultaneous clear
			if (global_overcurrent_flag != oc_flag_prev_reg)
				overcurrent_change_flag_reg <= 1'b1; // RULE8
			else if (wr_status && req_i.wdata[`BIT_OC_CHANGE])
				overcurrent_change_flag_reg <= 1'b0; // RULE8
		end
	end

	// ----------------------------------------
	// Remote wakeup
	// ----------------------------------------
	logic wakeup_enable_reg;
	logic clear_wakeup_enable;
	logic [15:0] conn_prev_reg;
	logic resume_event;
	logic resume_seen_interrupt_reg;
	assign clear_wakeup_enable = wr_status && req_i.wdata[`BIT_CLR_WAKE];
	assign resume_event = wakeup_enable_reg
		&& |(conn_reg & ~conn_prev_reg & `PORT_VALID_MASK); // RULE12

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			wakeup_enable_reg <= 1'b0;
		else if (wr_status && req_i.wdata[`BIT_WAKE_EN])
			wakeup_enable_reg <= 1'b1; // RULE12
		else if (clear_wakeup_enable)
			wakeup_enable_reg <= 1'b0; // RULE7
	end

	// Suspend to resume transition: held until software reads irq status
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			conn_prev_reg <= 16'h0000;
			resume_seen_interrupt_reg <= 1'b0;
		end
		else
		begin
			conn_prev_reg <= conn_reg;
			if (resume_event)
				resume_seen_interrupt_reg <= 1'b1; // RULE12
			else if (irq_rd)
				resume_seen_interrupt_reg <= 1'b0;
		end
	end
	assign resume_seen_interrupt_o = resume_seen_interrupt_reg;

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	logic [`IRQ_WIDTH-1:0] irq_status_reg;
	logic [`IRQ_WIDTH-1:0] irq_mask_reg;
	logic [`IRQ_WIDTH-1:0] irq_events;
	logic oc_change_seen_reg;
	assign irq_events = {overcurrent_change_flag_reg && !oc_change_seen_reg, resume_event};

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			oc_change_seen_reg <= 1'b0;
		else
			oc_change_seen_reg <= overcurrent_change_flag_reg;
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			irq_status_reg <= '0;
			irq_mask_reg <= '0;
		end
		else
		begin
			// Events raised in the reading cycle survive the clear
			irq_status_reg <= (irq_rd ? '0 : irq_status_reg) | irq_events;
			if (wr_mask)
				irq_mask_reg <= req_i.wdata[`IRQ_WIDTH-1:0];
		end
	end
	assign irq_o = |(irq_status_reg & irq_mask_reg);

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Read data stand one cycle and are zero otherwise, so idle cycles never alias
	logic [31:0] rdata_reg;
	logic [31:0] status_word;
	always_comb
	begin
		status_word = 32'h00000000; // RULE9 RULE17
		status_word[`BIT_OC_CHANGE] = overcurrent_change_flag_reg;
		status_word[`BIT_WAKE_EN] = wakeup_enable_reg;
		status_word[`BIT_OVERCURRENT] = global_overcurrent_flag;
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rdata_reg <= 32'h00000000;
		else if (req_i.rd)
		begin
			unique case (req_i.addr)
				`ADDR_GLOBAL_STATUS: rdata_reg <= status_word;
				`ADDR_PORT_POWER_REMOVABLE:
					rdata_reg <= {port_power_mask_reg, device_nonremovable_bits_reg};
				`ADDR_IRQ_STATUS: rdata_reg <= {30'h0, irq_status_reg};
				`ADDR_IRQ_MASK: rdata_reg <= {30'h0, irq_mask_reg};
				`ADDR_PORT_POWER: rdata_reg <= {16'h0000, port_powered_state_reg};
				default: rdata_reg <= 32'h00000000;
			endcase
		end
		else
			rdata_reg <= 32'h00000000;
	end
	assign rdata_o = rdata_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_masked_port_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE1
		(cfg_reg.power_switching_select_mode && !wr_port_cmd) |=>
		((port_powered_state_reg & $past(port_power_mask_reg))
		== ($past(port_powered_state_reg) & $past(port_power_mask_reg))))
		else $error("masked port power changed without port command");
	a_global_on_all: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE10
		(global_power_on_cmd && !global_power_off_cmd && !cfg_reg.power_switching_select_mode)
		|=> (port_powered_state_reg == `PORT_VALID_MASK))
		else $error("global power on missed a port");
	a_global_off_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE16
		global_power_off_cmd |=> ((port_powered_state_reg & $past(global_sel)) == 16'h0000))
		else $error("global power off left a port on");
	a_oc_change_set: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE8
		(global_overcurrent_flag != oc_flag_prev_reg) |=> overcurrent_change_flag_reg)
		else $error("overcurrent change not flagged");
	a_wake_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE7
		(clear_wakeup_enable && !req_i.wdata[`BIT_WAKE_EN]) |=> !wakeup_enable_reg)
		else $error("wakeup enable not cleared");
	a_resume_raise: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE12
		resume_event |=> resume_seen_interrupt_o ##0 irq_status_reg[`IRQ_BIT_RESUME])
		else $error("resume not raised");
	a_status_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE9
		(req_i.rd && req_i.addr == `ADDR_GLOBAL_STATUS) |=>
		(rdata_o[`BIT_POWER_ON] == 1'b0 && rdata_o[`BIT_POWER_OFF] == 1'b0))
		else $error("unsupported status bits read nonzero");
	a_oc_per_port: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE14
		cfg_reg.per_port_overcurrent |-> !global_overcurrent_flag)
		else $error("indicator set under per-port reporting");
	// Read-back checks look one cycle after the strobe, while the read data stand
	a_oc_read_one: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE13
		(rd_status && cfg_reg.global_overcurrent && !cfg_reg.per_port_overcurrent)
		|=> rdata_o[`BIT_OVERCURRENT])
		else $error("overcurrent indicator read as zero");
	a_oc_read_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE14
		(rd_status && cfg_reg.per_port_overcurrent)
		|=> !rdata_o[`BIT_OVERCURRENT])
		else $error("overcurrent indicator read as one");
	a_status_unused: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE7 RULE17
		rd_status
		|=> (rdata_o[31:18] == 14'h0 && rdata_o[14:2] == 13'h0))
		else $error("unused status bits read nonzero");
	a_desc_write: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE4 RULE5
		wr_desc
		|=> ({port_power_mask_reg, device_nonremovable_bits_reg}
		== ($past(req_i.wdata) & {`PORT_VALID_MASK, `PORT_VALID_MASK})))
		else $error("descriptor write not stored");
	a_desc_reserved: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE6
		rd_hit(req_i, `ADDR_PORT_POWER_REMOVABLE)
		|=> (rdata_o[16] == 1'b0 && rdata_o[0] == 1'b0))
		else $error("reserved descriptor bits read nonzero");
	a_unmasked_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE2
		(cfg_reg.power_switching_select_mode && !wr_status)
		|=> ((port_powered_state_reg & ~$past(port_power_mask_reg))
		== ($past(port_powered_state_reg) & ~$past(port_power_mask_reg))))
		else $error("unmasked port power changed without global command");
	a_global_on_unmasked: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE11
		(global_power_on_cmd && !global_power_off_cmd && cfg_reg.power_switching_select_mode)
		|=> (((port_powered_state_reg | $past(port_power_mask_reg)) & `PORT_VALID_MASK)
		== `PORT_VALID_MASK))
		else $error("global power on missed an unmasked port");
	a_port_cmd_ignored: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE3
		(wr_port_cmd && !cfg_reg.power_switching_select_mode)
		|=> (port_powered_state_reg == $past(port_powered_state_reg)))
		else $error("port command acted in global mode");
	a_wake_set: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE12
		(wr_status && req_i.wdata[`BIT_WAKE_EN])
		|=> wakeup_enable_reg)
		else $error("wakeup enable not set");
	a_oc_change_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE8
		(wr_status && req_i.wdata[`BIT_OC_CHANGE]
		&& global_overcurrent_flag == oc_flag_prev_reg)
		|=> !overcurrent_change_flag_reg)
		else $error("overcurrent change flag not cleared");
	a_resume_quiet: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE12
		(!wakeup_enable_reg && !resume_seen_interrupt_o)
		|=> !resume_seen_interrupt_o)
		else $error("resume raised with wakeup disabled");
endmodule : usb_root_hub_power_status

//--- sim/rh_port_model.sv
// Downstream port and power switch model
`timescale 1ns/1ps
module rh_port_model (
	input wire logic clk_i,
	input wire logic [15:0] port_powered_state_i,
	input wire logic [15:0] attach_i,
	input wire logic short_i,
	output logic [15:0] connection_change_flag_o,
	output logic global_overcurrent_o
);
	// ------------------------------------------------------------
	// Port events
	// ------------------------------------------------------------
	// Only a powered port can see an attach or draw fault current
	always_ff @(posedge clk_i)
	begin
		connection_change_flag_o <= attach_i & port_powered_state_i & 16'hfffe;
		global_overcurrent_o <= short_i & (|port_powered_state_i);
	end
endmodule : rh_port_model

//--- sim/tb_usb_root_hub_power_status.sv
// Self-checking bench for the root hub power and status block
`timescale 1ns/1ps
`include "rh_power_defines.svh"
module tb_usb_root_hub_power_status;
	import rh_power_pkg::*;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	reg_req_t req = '0;
	hub_cfg_t cfg;
	logic mode = 1'b0;
	logic ppoc = 1'b0;
	logic short_i = 1'b0;
	logic goc;
	logic [15:0] attach = 16'h0000;
	logic [15:0] conn;
	logic [31:0] rdata_o;
	logic [15:0] pw;
	logic resume_o;
	logic irq_o;
	logic [31:0] d;
	logic [31:0] rnd;
	logic [15:0] m;
	int n_mismatch = 0;
	int checks = 0;
	int cycles = 0;
	int exp_pw = 0;
	always #25 clk_i = ~clk_i;
	assign cfg = {mode, ppoc, goc};
	usb_root_hub_power_status i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req),
		.rdata_o(rdata_o), .cfg_i(cfg), .connection_change_flag_i(conn),
		.port_powered_state_o(pw), .resume_seen_interrupt_o(resume_o), .irq_o(irq_o));
	rh_port_model i_far (.clk_i(clk_i), .port_powered_state_i(pw), .attach_i(attach),
		.short_i(short_i), .connection_change_flag_o(conn), .global_overcurrent_o(goc));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task complete_run;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge clk_i);
		req.addr <= a;
		req.wdata <= v;
		req.wr <= 1'b1;
		@(posedge clk_i);
		req.wr <= 1'b0;
		#1;
	endtask : wr
	task rd(input logic [31:0] a);
		@(posedge clk_i);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk_i);
		req.rd <= 1'b0;
		#1;
		d = rdata_o;
	endtask : rd
	task settle;
		// Config and port lines pass a two stage synchroniser
		repeat (6) @(posedge clk_i);
		#1;
	endtask : settle
	// Bound the run in case a handshake hangs
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles >= 5000)
		begin
			n_mismatch++;
			complete_run();
		end
	end
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		void'($urandom(33518));
		repeat (20) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rd(`ADDR_GLOBAL_STATUS); chk(d, 32'h0);
		rd(32'h90101200); chk(d, 32'h0);
		rnd = $urandom;
		wr(`ADDR_PORT_POWER_REMOVABLE, rnd);
		rd(`ADDR_PORT_POWER_REMOVABLE); chk(d, rnd & 32'hfffefffe);
		m = rnd[31:16] & 16'hfffe;
		$display("test reset and descriptor done");
		wr(`ADDR_GLOBAL_STATUS, 32'h00010000); chk(pw, 32'hfffe);
		rd(`ADDR_GLOBAL_STATUS); chk(d, 32'h0);
		wr(`ADDR_PORT_CMD, 32'h0000fffe); chk(pw, 32'hfffe);
		wr(`ADDR_GLOBAL_STATUS, 32'h1); chk(pw, 32'h0);
		$display("test global switching done");
		mode <= 1'b1;
		settle();
		exp_pw = ~m & 16'hfffe;
		wr(`ADDR_GLOBAL_STATUS, 32'h00010000); chk(pw, exp_pw);
		exp_pw = 16'hfffe;
		wr(`ADDR_PORT_CMD, 32'hffff0000); chk(pw, exp_pw);
		rd(`ADDR_PORT_POWER); chk(d, exp_pw);
		exp_pw = m;
		wr(`ADDR_GLOBAL_STATUS, 32'h1); chk(pw, exp_pw);
		wr(`ADDR_PORT_CMD, 32'h0000ffff); chk(pw, 32'h0);
		$display("test per-port switching done");
		wr(`ADDR_PORT_CMD, 32'hffff0000);
		wr(`ADDR_GLOBAL_STATUS, 32'h00018000);
		rd(`ADDR_GLOBAL_STATUS); chk(d, 32'h00008000);
		wr(`ADDR_IRQ_MASK, 32'h3);
		rd(`ADDR_IRQ_MASK); chk(d, 32'h3);
		attach <= 16'h0008;
		settle();
		chk({resume_o, irq_o}, 2'b11);
		rd(`ADDR_IRQ_STATUS); chk(d, 32'h1);
		chk({resume_o, irq_o}, 2'b00);
		attach <= 16'h0000;
		wr(`ADDR_GLOBAL_STATUS, 32'h80000000);
		rd(`ADDR_GLOBAL_STATUS); chk(d, 32'h0);
		attach <= 16'h0020;
		settle();
		chk({resume_o, irq_o}, 2'b00);
		$display("test wakeup done");
		short_i <= 1'b1;
		settle();
		rd(`ADDR_GLOBAL_STATUS); chk(d, 32'h00020002);
		chk(irq_o, 1'b1);
		rd(`ADDR_IRQ_STATUS); chk(d, 32'h2);
		chk(irq_o, 1'b0);
		wr(`ADDR_GLOBAL_STATUS, 32'h00020000);
		rd(`ADDR_GLOBAL_STATUS); chk(d, 32'h2);
		short_i <= 1'b0;
		settle();
		rd(`ADDR_GLOBAL_STATUS); chk(d, 32'h00020000);
		wr(`ADDR_GLOBAL_STATUS, 32'h00020000);
		ppoc <= 1'b1;
		short_i <= 1'b1;
		settle();
		rd(`ADDR_GLOBAL_STATUS); chk(d, 32'h0);
		$display("test overcurrent done");
		complete_run();
	end
endmodule : tb_usb_root_hub_power_status
